//--- bench/odser_far_model.sv
// Far-side oscillator model: recovers one frequency sample per symbol
`timescale 1ns/10ps
module odser_far_model #(
    parameter int PERIOD = 12
) (
    input  wire logic       clk_in,
    input  wire logic       osc_on_in,
    input  wire logic [6:0] dev_in,
    output logic            sym_valid_out,
    output logic [6:0]      sym_dev_out
);
    logic       locked_reg = 1'b0;
    logic       valid_reg  = 1'b0;
    logic [6:0] dev_reg    = 7'h00;
    int         cnt_reg    = 0;

    assign sym_valid_out = valid_reg;
    assign sym_dev_out   = dev_reg;
    // Locks on the first deviated symbol, so a frame must open with a one
    always @(posedge clk_in) begin
        valid_reg <= 1'b0;
        if (!osc_on_in) begin
            locked_reg <= 1'b0;
        end else if (!locked_reg) begin
            if (dev_in != 7'h00) begin
                locked_reg <= 1'b1;
                cnt_reg    <= PERIOD / 2;
            end
        end else if (cnt_reg == 1) begin
            valid_reg <= 1'b1;
            dev_reg   <= dev_in;
            cnt_reg       <= PERIOD;
        end else begin
            cnt_reg <= cnt_reg - 1;
        end
    end
endmodule // odser_far_model

//--- bench/odser_top_tb.sv
// Self-checking bench for the output data serializer
`timescale 1ns/10ps
module odser_top_tb
    import odser_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd, empty, amp_on, div_on, osc_on, sym_valid;
    logic [4:0]  slice_in, slice_out;
    logic [6:0]  dev_in, dev_out, sym_dev;
    logic [31:0] rng = 32'h12;
    logic [6:0]  exp_q[$];
    int          err_count = 0;
    int          num_checks = 0;

    always #4 clk = ~clk;

    odser_top dut_u (
        .CLK_IN(clk), .RESETN_IN(rst_n), .SFR_ADDR_IN(addr),
        .SFR_WDATA_IN(wdata), .SFR_WR_IN(wr), .SFR_RD_IN(rd),
        .AMP_SLICE_COUNT_IN(slice_in), .FSK_DEVIATION_IN(dev_in),
        .SFR_RDATA_OUT(rdata), .HOLD_EMPTY_OUT(empty),
        .AMP_ON_OUT(amp_on), .AMP_SLICE_OUT(slice_out),
        .DIVIDER_ON_OUT(div_on), .LC_OSCILLATOR_ON_OUT(osc_on),
        .FREQ_DEV_OUT(dev_out)
    );
    // Symbol period of the FSK run: rate 6 times divider 2
    odser_far_model #(.PERIOD(12)) far_u (
        .clk_in(clk), .osc_on_in(osc_on), .dev_in(dev_out),
        .sym_valid_out(sym_valid), .sym_dev_out(sym_dev)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction

    task automatic stop_test();
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp, "register read");
    endtask

    // Notes the expected symbols, then hands the group over
    task automatic send(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++)
            exp_q.push_back(d[i] ? dev_in : 7'h00);
        sfr_wr(ODSER_ADDR_DATA, d);
        @(negedge clk);
        chk({7'h00, empty}, 8'h00, "empty after write");
    endtask

    task automatic wait_empty();
        int n;
        n = 0;
        while (empty !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, empty}, 8'h01, "holding register reload");
    endtask

    task automatic wait_off();
        int n;
        n = 0;
        while ({amp_on, div_on, osc_on} !== 3'b000 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk({5'h00, amp_on, div_on, osc_on}, 8'h00, "power off");
    endtask

    always @(posedge clk) begin
        if (sym_valid && exp_q.size() > 0)
            chk({1'b0, sym_dev}, {1'b0, exp_q.pop_front()}, "symbol");
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        logic [7:0] r;
        int         n;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        r = rnd();
        slice_in = {1'b1, r[3:0]};
        r = rnd();
        dev_in = {1'b1, r[5:0]};
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        sfr_rd(ODSER_ADDR_CTRL, ODSER_CTRL_RESET);
        sfr_rd(ODSER_ADDR_TIMING, ODSER_TIMING_RESET);
        sfr_wr(ODSER_ADDR_RATE_HI, 8'hFF);
        sfr_rd(ODSER_ADDR_RATE_HI, 8'h7F);
        sfr_rd(8'hB0, ODSER_READ_ZERO);
        sfr_wr(ODSER_ADDR_RATE_HI, 8'h00);
        sfr_wr(ODSER_ADDR_RATE_LO, 8'h06);
        // FSK: two 8-symbol groups, one 5-symbol group, then all ones
        sfr_wr(ODSER_ADDR_TIMING, 8'hE1);
        sfr_rd(ODSER_ADDR_TIMING, 8'hE1);
        sfr_wr(ODSER_ADDR_CTRL, 8'hD1);
        send(rnd() | 8'h01, 8);
        wait_empty();
        send(rnd(), 8);
        wait_empty();
        sfr_wr(ODSER_ADDR_TIMING, 8'h81);
        send(rnd(), 5);
        for (int i = 0; i < 6; i++)
            exp_q.push_back(dev_in);
        n = 0;
        while (exp_q.size() > 0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(exp_q.size(), 8'h00, "symbols left over");
        sfr_wr(ODSER_ADDR_CTRL, 8'h00);
        wait_off();
        // Forcing with OOK selected shows the overrides win
        sfr_wr(ODSER_ADDR_CTRL, 8'h2E);
        repeat (4) @(negedge clk);
        chk({1'b0, dev_out}, {1'b0, dev_in}, "forced deviation");
        chk({7'h00, osc_on}, 8'h01, "forced oscillator");
        chk({7'h00, div_on}, 8'h01, "forced divider");
        chk({7'h00, amp_on}, 8'h01, "forced amplifier");
        chk({3'h0, slice_out}, {3'h0, slice_in}, "slice pass");
        sfr_wr(ODSER_ADDR_CTRL, 8'h00);
        wait_off();
        // OOK, stop at end of data, edge steps of 2 clocks
        sfr_wr(ODSER_ADDR_RATE_LO, 8'h28);
        sfr_wr(ODSER_ADDR_TIMING, 8'hE8);
        sfr_wr(ODSER_ADDR_CTRL, 8'h01);
        send(8'hFF, 0);
        n = 0;
        while (slice_out === 5'h00 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (slice_out !== slice_in && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(n[7:0], 8'h0E, "ramp length");
        chk({7'h00, amp_on}, 8'h01, "OOK one keys amplifier");
        chk({1'b0, dev_out}, 8'h00, "OOK nominal frequency");
        wait_off();
        chk({7'h00, empty}, 8'h01, "empty after stop");
        // FSK tails: zeros after the group, then the group repeated
        sfr_wr(ODSER_ADDR_RATE_LO, 8'h06);
        sfr_wr(ODSER_ADDR_TIMING, 8'hE1);
        for (int m = 0; m < 2; m++) begin
            sfr_wr(ODSER_ADDR_CTRL, m ? 8'h51 : 8'h91);
            r = rnd() | 8'h01;
            send(r, 8);
            for (int i = 0; i < 8; i++)
                exp_q.push_back((m && r[i]) ? dev_in : 7'h00);
            n = 0;
            while (exp_q.size() > 0 && n < 3000) begin
                @(negedge clk);
                n++;
            end
            chk(exp_q.size(), 8'h00, "tail symbols left over");
            sfr_wr(ODSER_ADDR_CTRL, 8'h00);
            wait_off();
        end
        stop_test();
    end
endmodule // odser_top_tb

//--- design/odser_buf.sv
// Two-entry valid/ready buffer between shift stage and modulator
`timescale 1ns/10ps
module odser_buf #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    if (W < 1) begin : g_bad_width
        $error("odser_buf: W must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0]   cnt;
    } odser_buf_st_t;

    odser_buf_st_t st_reg;
    odser_buf_st_t st_next;
    logic          push;
    logic          pop;

    assign in_ready_out  = (st_reg.cnt != 2'h2);
    assign out_valid_out = (st_reg.cnt != 2'h0);
    assign out_data_out  = st_reg.e0;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        st_next = st_reg;
        if (pop) begin
            st_next.e0 = st_reg.e1;
        end
        if (push) begin
            if ((st_reg.cnt == 2'h0) || ((st_reg.cnt == 2'h1) && pop)) begin
                st_next.e0 = in_data_in;
            end else begin
                st_next.e1 = in_data_in;
            end
        end
        st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // odser_buf

//--- design/odser_div.sv
// Enable-pulse divider: one tick every limit+1 input enables
`timescale 1ns/10ps
module odser_div #(
    parameter int W = 3
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         en_in,
    input  wire logic [W-1:0] limit_in,
    output logic              tick_out
);
    if (W < 1) begin : g_bad_width
        $error("odser_div: W must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } odser_div_st_t;

    odser_div_st_t st_reg;
    odser_div_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (en_in) begin
            // >= so that a lowered limit never strands the counter
            if (st_reg.cnt >= limit_in) begin
                st_next.cnt  = '0;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;
endmodule // odser_div

//--- design/odser_pkg.sv
// Register map, field positions and types of the output data serializer
package odser_pkg;
    localparam logic [7:0] ODSER_ADDR_CTRL    = 8'hA9;
    localparam logic [7:0] ODSER_ADDR_TIMING  = 8'hAA;
    localparam logic [7:0] ODSER_ADDR_DATA    = 8'hAB;
    localparam logic [7:0] ODSER_ADDR_RATE_LO = 8'hAC;
    localparam logic [7:0] ODSER_ADDR_RATE_HI = 8'hAD;

    localparam logic [7:0] ODSER_CTRL_RESET   = 8'h00;
    localparam logic [7:0] ODSER_TIMING_RESET = 8'h00;
    localparam logic [7:0] ODSER_READ_ZERO    = 8'h00;

    localparam int ODSER_CTRL_EN        = 0;
    localparam int ODSER_CTRL_FORCE_AMP = 1;
    localparam int ODSER_CTRL_FORCE_DIV = 2;
    localparam int ODSER_CTRL_FORCE_OSC = 3;
    localparam int ODSER_CTRL_MOD_SEL   = 4;
    localparam int ODSER_CTRL_FORCE_DEV = 5;
    localparam int ODSER_CTRL_EOD_LSB   = 6;

    localparam int ODSER_TIM_CKDIV_LSB  = 0;
    localparam int ODSER_TIM_EDGE_LSB   = 3;
    localparam int ODSER_TIM_GROUP_LSB  = 5;

    localparam logic [1:0] ODSER_EOD_OFF    = 2'h0;
    localparam logic [1:0] ODSER_EOD_REPEAT = 2'h1;
    localparam logic [1:0] ODSER_EOD_ZEROS  = 2'h2;
    localparam logic [1:0] ODSER_EOD_ONES   = 2'h3;

    // An amplifier edge is this many edge-clock steps long
    localparam logic [3:0] ODSER_EDGE_STEPS = 4'h8;

    typedef enum logic [1:0] {
        ODSER_IDLE = 2'b00,
        ODSER_RUN  = 2'b01,
        ODSER_STOP = 2'b10
    } odser_state_t;
endpackage

//--- design/odser_top.sv
// Output data serializer: registers, shift stage, modulation, power
`timescale 1ns/10ps
module odser_top
    import odser_pkg::*;
#(
    parameter int DEV_W   = 7,
    parameter int SLICE_W = 5
) (
    input  wire logic               CLK_IN,
    input  wire logic               RESETN_IN,
    input  wire logic [7:0]         SFR_ADDR_IN,
    input  wire logic [7:0]         SFR_WDATA_IN,
    input  wire logic               SFR_WR_IN,
    input  wire logic               SFR_RD_IN,
    input  wire logic [SLICE_W-1:0] AMP_SLICE_COUNT_IN,
    input  wire logic [DEV_W-1:0]   FSK_DEVIATION_IN,
    output logic [7:0]              SFR_RDATA_OUT,
    output logic                    HOLD_EMPTY_OUT,
    output logic                    AMP_ON_OUT,
    output logic [SLICE_W-1:0]      AMP_SLICE_OUT,
    output logic                    DIVIDER_ON_OUT,
    output logic                    LC_OSCILLATOR_ON_OUT,
    output logic [DEV_W-1:0]        FREQ_DEV_OUT
);
    if ((DEV_W < 1) || (SLICE_W < 1)) begin : g_bad_width
        $error("odser_top: DEV_W and SLICE_W must be at least 1");
    end

    typedef struct packed {
        logic [7:0]         ctrl;
        logic [7:0]         timing;
        logic [7:0]         hold;
        logic [7:0]         rate_lo;
        logic [6:0]         rate_hi;
        logic               empty;
        logic               notify;
        logic               hold_full;
        logic [7:0]         shift;
        logic [3:0]         left;
        logic [7:0]         last;
        logic [2:0]         last_size;
        odser_state_t       state;
        logic               sym;
        logic [3:0]         ramp;
        logic [7:0]         rdata;
        logic               amp_on;
        logic               div_on;
        logic               osc_on;
        logic [DEV_W-1:0]   dev;
        logic [SLICE_W-1:0] slice;
    } odser_st_t;

    odser_st_t st;
    odser_st_t nx;

    // Slice count scaled by ramp step out of the full edge length
    function automatic logic [SLICE_W-1:0] ramp_scale(
        input logic [SLICE_W-1:0] full,
        input logic [3:0]         step
    );
        logic [SLICE_W+3:0] prod;
        prod = {4'h0, full} * {{SLICE_W{1'b0}}, step};
        return prod[SLICE_W+2:3];
    endfunction

    logic        en;
    logic        force_amp;
    logic        force_div;
    logic        force_osc;
    logic        mod_sel;
    logic        force_dev;
    logic [1:0]  eod;
    logic [2:0]  group;
    logic [1:0]  edge_sel;
    logic [2:0]  ckdiv;
    logic [14:0] rate;
    logic [14:0] sym_limit;
    logic        wr_data;
    logic        load;
    logic        ods_tick;
    logic        edge_tick;
    logic        sym_tick;
    logic        push_valid;
    logic        push_data;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_data;
    logic        buf_pop;
    logic        amp_tgt;

    assign en        = st.ctrl[ODSER_CTRL_EN];
    assign force_amp = st.ctrl[ODSER_CTRL_FORCE_AMP];
    assign force_div = st.ctrl[ODSER_CTRL_FORCE_DIV];
    assign force_osc = st.ctrl[ODSER_CTRL_FORCE_OSC];
    assign mod_sel   = st.ctrl[ODSER_CTRL_MOD_SEL];
    assign force_dev = st.ctrl[ODSER_CTRL_FORCE_DEV];
    assign eod       = st.ctrl[ODSER_CTRL_EOD_LSB +: 2];
    assign group     = st.timing[ODSER_TIM_GROUP_LSB +: 3];
    assign edge_sel  = st.timing[ODSER_TIM_EDGE_LSB +: 2];
    assign ckdiv     = st.timing[ODSER_TIM_CKDIV_LSB +: 3];
    assign rate      = {st.rate_hi, st.rate_lo};
    // A zero rate cannot be divided by; it runs at the serializer clock
    assign sym_limit = (rate == 15'h0000) ? 15'h0000 : rate - 15'h0001;

    assign wr_data = SFR_WR_IN && (SFR_ADDR_IN == ODSER_ADDR_DATA);
    // A write in flight blocks the load so the new byte is never lost
    assign load    = en && (st.left == 4'h0) && st.hold_full && !wr_data;

    // Serializer clock enable: system clock over div+1
    odser_div #(
        .W (3)
    ) u_ck_div (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .en_in     (1'b1),
        .limit_in  (ckdiv),
        .tick_out  (ods_tick)
    );

    // Edge step every edge+1 serializer clocks, eight steps an edge
    odser_div #(
        .W (2)
    ) u_edge_div (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .en_in     (ods_tick),
        .limit_in  (edge_sel),
        .tick_out  (edge_tick)
    );

    // Symbol tick every rate serializer clocks
    odser_div #(
        .W (15)
    ) u_sym_div (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .en_in     (ods_tick),
        .limit_in  (sym_limit),
        .tick_out  (sym_tick)
    );

    // Symbols wait here so a late symbol tick loses none
    assign push_valid = en && ((st.left != 4'h0) ||
                        ((st.state == ODSER_RUN) && !st.hold_full &&
                         ((eod == ODSER_EOD_ZEROS) ||
                          (eod == ODSER_EOD_ONES))));
    assign push_data  = (st.left != 4'h0) ? st.shift[0]
                                          : (eod == ODSER_EOD_ONES);
    // Disabling drains the buffer so no stale symbol leads the next frame
    assign buf_pop    = !en || (sym_tick && (st.state == ODSER_RUN));

    odser_buf #(
        .W (1)
    ) u_sym_buf (
        .clk_in        (CLK_IN),
        .resetn_in     (RESETN_IN),
        .in_valid_in   (push_valid),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (push_data),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (buf_pop),
        .out_data_out  (buf_out_data)
    );

    assign amp_tgt = (st.state == ODSER_RUN) && (mod_sel || st.sym);

    always_comb begin
        nx        = st;
        nx.notify = 1'b0;

        if (SFR_WR_IN) begin
            case (SFR_ADDR_IN)
                ODSER_ADDR_CTRL: begin
                    nx.ctrl = SFR_WDATA_IN;
                end
                ODSER_ADDR_TIMING: begin
                    nx.timing = SFR_WDATA_IN;
                end
                ODSER_ADDR_DATA: begin
                    nx.hold   = SFR_WDATA_IN;
                    nx.empty  = 1'b0;
                    nx.notify = 1'b1;
                end
                ODSER_ADDR_RATE_LO: begin
                    nx.rate_lo = SFR_WDATA_IN;
                end
                ODSER_ADDR_RATE_HI: begin
                    nx.rate_hi = SFR_WDATA_IN[6:0];
                end
                default: begin
                end
            endcase
        end

        // The notify pulse comes once the byte is stable in hold
        if (st.notify) begin
            nx.hold_full = 1'b1;
        end

        if (SFR_RD_IN) begin
            case (SFR_ADDR_IN)
                ODSER_ADDR_CTRL:    nx.rdata = st.ctrl;
                ODSER_ADDR_TIMING:  nx.rdata = st.timing;
                ODSER_ADDR_DATA:    nx.rdata = st.hold;
                ODSER_ADDR_RATE_LO: nx.rdata = st.rate_lo;
                ODSER_ADDR_RATE_HI: nx.rdata = {1'b0, st.rate_hi};
                default:            nx.rdata = ODSER_READ_ZERO;
            endcase
        end

        // Shift stage
        if (!en) begin
            nx.left = 4'h0;
        end else if (st.left != 4'h0) begin
            if (buf_in_ready) begin
                nx.shift = {1'b0, st.shift[7:1]};
                nx.left  = st.left - 4'h1;
            end
        end else if (load) begin
            nx.shift     = st.hold;
            nx.left      = {1'b0, group} + 4'h1;
            nx.last      = st.hold;
            nx.last_size = group;
            nx.hold_full = 1'b0;
            nx.empty     = 1'b1;
        end else if ((st.state == ODSER_RUN) &&
                     (eod == ODSER_EOD_REPEAT)) begin
            nx.shift = st.last;
            nx.left  = {1'b0, st.last_size} + 4'h1;
        end

        case (st.state)
            ODSER_IDLE: begin
                nx.sym = 1'b0;
                if (en && (st.hold_full || buf_out_valid)) begin
                    nx.state = ODSER_RUN;
                end
            end
            ODSER_RUN: begin
                if (!en) begin
                    nx.state = ODSER_STOP;
                end else if (sym_tick) begin
                    if (buf_out_valid) begin
                        nx.sym = buf_out_data;
                    end else if ((eod == ODSER_EOD_OFF) &&
                                 (st.left == 4'h0) && !st.hold_full) begin
                        nx.state = ODSER_STOP;
                    end
                end
            end
            ODSER_STOP: begin
                nx.sym = 1'b0;
                if (st.ramp == 4'h0) begin
                    nx.state = ODSER_IDLE;
                end
            end
            default: begin
                nx.state = ODSER_IDLE;
            end
        endcase

        // Amplifier edge shaping, one slice step per edge tick
        if (edge_tick) begin
            if (amp_tgt && (st.ramp < ODSER_EDGE_STEPS)) begin
                nx.ramp = st.ramp + 4'h1;
            end else if (!amp_tgt && (st.ramp != 4'h0)) begin
                nx.ramp = st.ramp - 4'h1;
            end
        end

        nx.amp_on = force_amp || (nx.ramp != 4'h0);
        nx.slice  = force_amp ? AMP_SLICE_COUNT_IN
                              : ramp_scale(AMP_SLICE_COUNT_IN, nx.ramp);
        nx.div_on = force_div || (nx.state != ODSER_IDLE);
        nx.osc_on = force_osc || (nx.state != ODSER_IDLE);

        if (force_dev) begin
            nx.dev = FSK_DEVIATION_IN;
        end else if (mod_sel && (nx.state == ODSER_RUN) && nx.sym) begin
            nx.dev = FSK_DEVIATION_IN;
        end else begin
            nx.dev = '0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            st        <= '0;
            st.ctrl   <= ODSER_CTRL_RESET;
            st.timing <= ODSER_TIMING_RESET;
            st.empty  <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign SFR_RDATA_OUT        = st.rdata;
    assign HOLD_EMPTY_OUT       = st.empty;
    assign AMP_ON_OUT           = st.amp_on;
    assign AMP_SLICE_OUT        = st.slice;
    assign DIVIDER_ON_OUT       = st.div_on;
    assign LC_OSCILLATOR_ON_OUT = st.osc_on;
    assign FREQ_DEV_OUT         = st.dev;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence data_write_s;
        wr_data;
    endsequence

    sequence notify_then_full_s;
        st.notify ##1 st.hold_full;
    endsequence

    sequence run_dry_s;
        (st.state == ODSER_RUN) && en && sym_tick && !buf_out_valid &&
        (eod == ODSER_EOD_OFF) && (st.left == 4'h0) && !st.hold_full;
    endsequence

    data_write_a: assert property (
        data_write_s |=> !st.empty ##0 notify_then_full_s)
        else $error("data write did not clear empty and notify");

    load_empty_a: assert property (
        load |=> st.empty && !st.hold_full)
        else $error("shift load did not set empty");

    group_size_a: assert property (
        load |=> (st.left == {1'b0, $past(group)} + 4'h1))
        else $error("group length is not field plus one");

    eod_stop_a: assert property (
        run_dry_s |=> (st.state == ODSER_STOP) ##1 (st.state != ODSER_RUN))
        else $error("data ran out without stopping");

    force_amp_a: assert property (
        force_amp |=> AMP_ON_OUT &&
        (AMP_SLICE_OUT == $past(AMP_SLICE_COUNT_IN)))
        else $error("forced amplifier did not pass slice count");

    force_dev_a: assert property (
        force_dev |=> (FREQ_DEV_OUT == $past(FSK_DEVIATION_IN)))
        else $error("forced deviation not applied");

    ook_dev_a: assert property (
        !force_dev && !mod_sel |=> (FREQ_DEV_OUT == '0))
        else $error("deviation seen in on-off keying");

    force_power_a: assert property (
        force_osc && force_div |=> LC_OSCILLATOR_ON_OUT && DIVIDER_ON_OUT)
        else $error("forced oscillator or divider is off");

    disable_a: assert property (
        !en |=> (st.left == 4'h0) && (st.state != ODSER_RUN))
        else $error("serializer kept running while disabled");

    edge_step_a: assert property (
        (st.ramp != $past(st.ramp)) |-> $past(edge_tick))
        else $error("amplifier ramp moved without an edge tick");
endmodule // odser_top
